// ==== src/spi_engine.sv ====
`timescale 1ns/100ps
// How it works
// - Master starts every transfer and drives one of four select lines.
// - Frame length 4 to 16 bits, 8 after reset.
// - Bit order MSB first or LSB first, selectable.
// - Select-framed: select low across back-to-back frames, high when idle.
// - Select-framed slave counts bits itself to split frames.
// - Master idles clock low for polarity 0, high for polarity 1.
// - Phase 0 samples on leading edge, phase 1 on trailing edge.
// - Modes 0,3 drive falling capture rising; modes 1,2 the reverse.
// - Phase 0 puts first bit on the line before the first edge.
// - Engine runs when block control bits 25:24 hold 01 and the variant is not 11.
// - Variant 00 select-framed, 01 pulse-framed.
// - Interface control bit 2 phase, bit 3 polarity.
// - Pulse-framed select is an active-high pulse of one bit.
// - Bit 1 puts pulse one bit early when 1, on first bit when 0.
// - Early pulse of next frame overlaps last bit of current frame.
// - Pulse-framed uses only mode 1.
// - Half-duplex: master sends then receives; lengths set independently.
// - Half-duplex: one idle bit between send and receive, none between transfers.
// - Half-duplex uses only mode 0.
// - Variant 10 selects half-duplex.
module spi_engine #(
   parameter logic [7:0] HALF_DIV = spi_pkg::HALF_DIV_DEF // Clocks per half bit
) (
   input logic sys_clk, // 100 MHz system clock
   input logic rst_n, // Synchronous reset, active low
   input logic [31:0] block_control_reg, // Block control word
   input logic [31:0] interface_control_reg, // Interface control word
   input logic master_mode, // 1 master, 0 slave
   input logic lsb_first, // Bit order select
   input logic [1:0] ss_index, // Slave addressed as master
   input logic len_we, // Load both frame lengths
   input logic [4:0] tx_len_in, // Send length, or full frame
   input logic [4:0] rx_len_in, // Half-duplex reply length
   input logic [15:0] tx_data, // Next frame to send
   input logic tx_valid, // Next frame present
   output logic tx_ready, // Frame taken this cycle
   output logic [15:0] rx_data, // Last received frame
   output logic rx_valid, // One-cycle receive strobe
   output logic busy, // Transfer in progress
   input logic sclk_in, // Serial clock pin in
   output logic sclk_out, // Serial clock pin out
   output logic sclk_oe_n, // Serial clock enable, low drives
   input logic mosi_in, // Master-out pin in
   output logic mosi_out, // Master-out pin out
   output logic mosi_oe_n, // Master-out enable, low drives
   input logic miso_in, // Master-in pin in
   output logic miso_out, // Master-in pin out
   output logic miso_oe_n, // Master-in enable, low drives
   input logic ss_in, // Select pin seen as slave
   output logic [spi_pkg::NUM_SS-1:0] ss_out // Selects: low active, pulse-framed high
);
   import spi_pkg::*;

   eng_t r;
   eng_t n;
   cfg_t c;
   logic tick;
   logic rise;
   logic fall;
   logic se;
   logic de;
   logic pulse;
   logic [5:0] last;
   logic [15:0] nrx;
   logic [8:0] plen;

   function automatic logic [4:0] clamp(input logic [4:0] l);
      clamp = (l < LEN_MIN) ? LEN_MIN : ((l > LEN_MAX) ? LEN_MAX : l);
   endfunction : clamp

   function automatic logic pick(input logic [15:0] sh, input logic [4:0] len, input logic lsb);
      pick = lsb ? sh[0] : sh[4'(len - 5'h01)];
   endfunction : pick

   function automatic logic [15:0] push(input logic [15:0] sh, input logic b,
                                        input logic [4:0] len, input logic lsb);
      // Bits above the frame are cleared first, else stale ones slide into it
      push = lsb ? (((sh & (16'hffff >> (5'h10 - len))) >> 1) | (16'(b) << (len - 5'h01)))
             : {sh[14:0], b};
   endfunction : push

   function automatic logic [15:0] keep(input logic [15:0] sh, input logic [4:0] len);
      keep = sh & (16'hffff >> (5'h10 - len));
   endfunction : keep

   // Configuration decode; fixed modes forced for the two other variants
   always_comb begin
      c.on = (block_control_reg[FLD_LO+1:FLD_LO] == PROTO_SPI)
             && (interface_control_reg[FLD_LO+1:FLD_LO] != 2'h3);
      c.mot = interface_control_reg[FLD_LO+1:FLD_LO] == VAR_SEL;
      c.ti = interface_control_reg[FLD_LO+1:FLD_LO] == VAR_PULSE;
      c.ns = interface_control_reg[FLD_LO+1:FLD_LO] == VAR_HALF;
      // phase and polarity bits; force modes 1 and 0
      c.cpol = c.mot & interface_control_reg[BIT_CPOL];
      c.cpha = c.ti | (c.mot & interface_control_reg[BIT_CPHA]);
      c.precede = interface_control_reg[BIT_PRECEDE];
   end

   // Bit index of the final bit of a frame
   assign last = c.ns ? ({1'b0, r.tx_len} + {1'b0, r.rx_len}) : ({1'b0, r.tx_len} - 6'h01);
   assign tick = r.div == (HALF_DIV - 8'h01);
   // Only the second synchroniser stage and the copy behind it are read
   assign rise = r.s2[0] & ~r.s3;
   assign fall = ~r.s2[0] & r.s3;
   // capture edge rises for modes 0 and 3, falls for 1 and 2
   assign se = (c.cpol ~^ c.cpha) ? rise : fall;
   assign de = (c.cpol ~^ c.cpha) ? fall : rise;

   // Next state of the whole engine
   always_comb begin
      n = r;
      tx_ready = 1'b0;
      pulse = 1'b0;
      nrx = r.rx_sh;
      n.rx_valid = 1'b0;
      n.s1 = {miso_in, ss_in, mosi_in, sclk_in};
      n.s2 = r.s1;
      n.s3 = r.s2[0];
      // lengths clamped to the legal range
      if (len_we) begin
         n.tx_len = clamp(tx_len_in);
         n.rx_len = clamp(rx_len_in);
      end
      if (!c.on) begin
         n.st = M_IDLE;
         n.act = 1'b0;
         n.chain = 1'b0;
      end else if (master_mode) begin
         // only the master starts a frame
         if (r.st == M_IDLE) begin
            n.h = 1'b0;
            n.div = 8'h00;
            if (tx_valid) begin
               tx_ready = 1'b1;
               n.tx_sh = tx_data;
               n.bitc = 6'h00;
               n.chain = 1'b0;
               // early pulse gets a bit of its own
               n.st = (c.ti && c.precede) ? M_PRE : M_DATA;
            end
         end else begin
            n.div = tick ? 8'h00 : r.div + 8'h01;
            if (tick) begin
               n.h = ~r.h;
            end
            // sample mid-bit, on leading edge for phase 0, trailing for 1
            if (tick && !r.h && r.st == M_DATA && (!c.ns || r.bitc > {1'b0, r.tx_len})) begin
               n.rx_sh = push(r.rx_sh, r.s2[3], c.ns ? r.rx_len : r.tx_len, lsb_first);
            end
            if (tick && r.h) begin
               if (r.st == M_PRE) begin
                  n.st = M_DATA;
               end else if (r.bitc == last) begin
                  n.rx_data = keep(r.rx_sh, c.ns ? r.rx_len : r.tx_len);
                  n.rx_valid = 1'b1;
                  // next frame follows at once; no idle bit between transfers
                  if (tx_valid) begin
                     tx_ready = 1'b1;
                     n.tx_sh = tx_data;
                     n.bitc = 6'h00;
                     n.chain = 1'b0;
                     n.st = (c.ti && c.precede && !r.chain) ? M_PRE : M_DATA;
                  end else begin
                     n.st = M_IDLE;
                  end
               end else begin
                  n.tx_sh = lsb_first ? (r.tx_sh >> 1) : (r.tx_sh << 1);
                  n.bitc = r.bitc + 6'h01;
                  // pulse for the next frame rides on the final bit
                  if (c.ti && c.precede && r.bitc + 6'h01 == last) begin
                     n.chain = tx_valid;
                  end
               end
            end
         end
      end else begin
         n.st = M_IDLE;
         // slave timing comes from pin clock edges seen through the sys_clk synchronisers
         if (!c.ti && r.s2[2]) begin
            n.act = 1'b0;
         end else if (!c.ti && !r.act) begin
            n.act = 1'b1;
            n.bitc = 6'h00;
            n.skip = c.cpha | c.ns;
         end
         if (!r.act && !r.have && tx_valid) begin
            tx_ready = 1'b1;
            n.tx_sh = tx_data;
            n.have = 1'b1;
         end
         if (se && (r.act || (c.ti && r.s2[2]))) begin
            // slave counts bits to find frame ends
            if (c.ti && r.s2[2] && c.precede) begin
               if (r.act && r.bitc == last) begin
                  nrx = push(r.rx_sh, r.s2[1], r.tx_len, lsb_first);
                  n.rx_data = keep(nrx, r.tx_len);
                  n.rx_valid = 1'b1;
                  tx_ready = tx_valid;
                  n.tx_sh = tx_valid ? tx_data : 16'h0000;
                  n.have = tx_valid;
               end
               n.act = 1'b1;
               n.bitc = 6'h00;
               n.skip = 1'b1;
            end else begin
               n.act = 1'b1;
               n.skip = 1'b0;
               n.bitc = (c.ti && r.s2[2]) ? 6'h00 : r.bitc;
               if (!c.ns || n.bitc < {1'b0, r.tx_len}) begin
                  nrx = push(r.rx_sh, r.s2[1], r.tx_len, lsb_first);
               end
               if (n.bitc == last) begin
                  n.rx_data = keep(nrx, r.tx_len);
                  n.rx_valid = 1'b1;
                  tx_ready = tx_valid;
                  n.tx_sh = tx_valid ? tx_data : 16'h0000;
                  n.have = tx_valid;
                  n.bitc = 6'h00;
                  n.skip = 1'b1;
                  n.act = ~c.ti;
               end else begin
                  n.bitc = n.bitc + 6'h01;
               end
            end
            n.rx_sh = nrx;
         end else if (de && r.act && (!c.ns || r.bitc > {1'b0, r.tx_len})) begin
            // first bit already loaded, so the first drive edge holds it
            if (r.skip) begin
               n.skip = 1'b0;
            end else begin
               n.tx_sh = lsb_first ? (r.tx_sh >> 1) : (r.tx_sh << 1);
            end
         end
         if (!c.ti && r.s2[2]) begin
            n.have = r.have & r.act ? 1'b0 : r.have;
         end
      end
      // one-bit pulse; early or on first bit; on final bit
      pulse = c.ti && master_mode && c.on && ((n.st == M_PRE)
              || (n.st == M_DATA && n.chain && n.bitc == last)
              || (n.st == M_DATA && !c.precede && n.bitc == 6'h00));
      // idle level is polarity; no edges while idle
      n.sclk = (n.st == M_IDLE) ? c.cpol : (c.cpol ^ (c.cpha ? ~n.h : n.h));
      // same order on both paths; miso uses the reply length in half-duplex
      n.mosi = pick(n.tx_sh, r.tx_len, lsb_first);
      n.miso = pick(n.tx_sh, c.ns ? r.rx_len : r.tx_len, lsb_first);
      // one select per slave; select-framed low while moving data, else high; pulse-framed carries the pulse
      for (int i = 0; i < NUM_SS; i++) begin
         n.ss[i] = c.ti ? (pulse && ss_index == 2'(i))
                   : ~(master_mode && n.st != M_IDLE && ss_index == 2'(i));
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         r <= '{st: M_IDLE, tx_len: LEN_DEF, rx_len: LEN_DEF, ss: '1, skip: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   // Pins: master drives clock and data out, slave drives reply when addressed or when pulse-framed
   assign sclk_out = r.sclk;
   assign sclk_oe_n = ~(c.on & master_mode);
   assign mosi_out = r.mosi;
   assign mosi_oe_n = ~(c.on & master_mode);
   assign miso_out = r.miso;
   assign miso_oe_n = ~(c.on & ~master_mode & (c.ti | ~r.s2[2]));
   assign ss_out = r.ss;
   assign rx_data = r.rx_data;
   assign rx_valid = r.rx_valid;
   assign busy = (r.st != M_IDLE) | r.act;

   // Length of the select pulse, read only by the check below
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         plen <= 9'h000;
      end else begin
         plen <= r.ss[ss_index] ? plen + 9'h001 : 9'h000;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   idle_clock_level_a: assert property (
      master_mode && r.st == M_IDLE && $stable(c) && $past(rst_n) |-> sclk_out == c.cpol)
      else $error("master clock not at idle level");
   idle_select_high_a: assert property (
      master_mode && !c.ti && r.st == M_IDLE && $past(r.st) == M_IDLE && $stable(c)
      && $past(c, 2) == c |-> &ss_out && $stable(sclk_out))
      else $error("select or clock active while idle");
   frame_len_range_a: assert property (
      r.tx_len >= LEN_MIN && r.tx_len <= LEN_MAX && r.rx_len >= LEN_MIN)
      else $error("frame length out of range");
   first_bit_setup_a: assert property (
      master_mode && !c.cpha && $past(r.st) == M_IDLE && r.st == M_DATA
      |-> (sclk_out == c.cpol) [*3])
      else $error("clock edge before first bit setup");
   select_held_low_a: assert property (
      master_mode && !c.ti && r.st == M_DATA && $stable(ss_index) && $stable(c)
      |-> !ss_out[ss_index])
      else $error("select released during frame");
   pulse_one_bit_a: assert property (
      c.ti && master_mode && $fell(ss_out[ss_index]) && $stable(ss_index) && $past(c, 2) == c
      |-> plen == {HALF_DIV, 1'b0})
      else $error("select pulse not one bit long");
   pulse_mode_one_a: assert property (
      c.ti && master_mode && r.st != M_IDLE && !r.h |-> sclk_out)
      else $error("pulse-framed clock not mode 1");
   half_duplex_mode_a: assert property (
      c.ns && master_mode && r.st == M_DATA && !r.h |-> !sclk_out)
      else $error("half-duplex clock not mode 0");
   proto_off_idle_a: assert property (
      block_control_reg[FLD_LO+1:FLD_LO] != PROTO_SPI |=> r.st == M_IDLE && !r.act)
      else $error("engine running with protocol off");
endmodule : spi_engine

// ==== src/spi_pkg.sv ====
package spi_pkg;
   // Protocol field of block_control_reg and variant field of interface_control_reg
   localparam int FLD_LO = 24;
   localparam logic [1:0] PROTO_SPI = 2'h1;
   localparam logic [1:0] VAR_SEL = 2'h0;
   localparam logic [1:0] VAR_PULSE = 2'h1;
   localparam logic [1:0] VAR_HALF = 2'h2;
   // Single bits of interface_control_reg
   localparam int BIT_PRECEDE = 1;
   localparam int BIT_CPHA = 2;
   localparam int BIT_CPOL = 3;
   // Frame length limits and reset value
   localparam logic [4:0] LEN_MIN = 5'h04;
   localparam logic [4:0] LEN_MAX = 5'h10;
   localparam logic [4:0] LEN_DEF = 5'h08;
   // System clocks per half serial bit when master
   localparam logic [7:0] HALF_DIV_DEF = 8'h04;
   localparam int NUM_SS = 4;

   // Master sequencer, Gray along idle, pulse bit, data
   typedef enum logic [1:0] {M_IDLE = 2'h0, M_PRE = 2'h1, M_DATA = 2'h3} mst_t;

   // Decoded configuration
   typedef struct packed {
      logic on;
      logic mot;
      logic ti;
      logic ns;
      logic cpol;
      logic cpha;
      logic precede;
   } cfg_t;

   // Whole engine state
   typedef struct packed {
      mst_t st;
      logic h;
      logic [7:0] div;
      logic [5:0] bitc;
      logic chain;
      logic act;
      logic skip;
      logic have;
      logic [15:0] tx_sh;
      logic [15:0] rx_sh;
      logic [15:0] rx_data;
      logic rx_valid;
      logic [4:0] tx_len;
      logic [4:0] rx_len;
      logic [3:0] s1;
      logic [3:0] s2;
      logic s3;
      logic sclk;
      logic mosi;
      logic miso;
      logic [NUM_SS-1:0] ss;
   } eng_t;
endpackage : spi_pkg

// ==== tb/spi_master_slave_engine_tb_top.sv ====
`timescale 1ns/100ps
module spi_master_slave_engine_tb_top;
   import spi_pkg::*;
   localparam logic [7:0] HD = 8'h06;
   localparam int BIT = 12;
   localparam logic [63:0] REPLY = 64'hc3a5_96e1_0f5a_7b2d;
   localparam logic [15:0] SLV = 16'ha659;
   localparam int LENS [4] = '{4, 16, 31, 3};
   typedef struct {logic [15:0] rx; logic [15:0] tx; logic [15:0] mask; bit crx; bit ctx;} exp_t;
   logic sys_clk, rst_n, master_mode, lsb_first, len_we, tx_valid, tx_ready, rx_valid, busy;
   logic sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, miso_m;
   logic sl_sclk, sl_mosi, sl_ss_n;
   logic [31:0] block_control_reg, interface_control_reg;
   logic [1:0] ss_index;
   logic [4:0] tx_len_in, rx_len_in;
   logic [15:0] tx_data, rx_data, seed, mrx;
   logic [3:0] ss_out;
   logic [63:0] got;
   int bad_count, checks, cyc, pw, len, rlen, cnt;
   int t_rx[$];
   exp_t expq[$];
   wire logic [1:0] mode_v = interface_control_reg[25:24];
   // Pin levels resolved from the engine's enables, else bench or model
   wire logic sclk_w = !sclk_oe_n ? sclk_out : sl_sclk;
   wire logic mosi_w = !mosi_oe_n ? mosi_out : sl_mosi;
   wire logic miso_w = !miso_oe_n ? miso_out : miso_m;
   // Pulse framing leaves the far side always listening
   wire logic part_sel_n = (mode_v == VAR_PULSE) ? 1'b0 : ss_out[ss_index];
   wire logic part_cpol = (mode_v == VAR_SEL) & interface_control_reg[3];
   wire logic part_cpha = (mode_v == VAR_SEL) ? interface_control_reg[2] : (mode_v == VAR_PULSE);

   spi_engine #(.HALF_DIV(HD)) u_spi_engine (
      .sys_clk(sys_clk), .rst_n(rst_n), .block_control_reg(block_control_reg),
      .interface_control_reg(interface_control_reg), .master_mode(master_mode),
      .lsb_first(lsb_first), .ss_index(ss_index), .len_we(len_we), .tx_len_in(tx_len_in),
      .rx_len_in(rx_len_in), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy), .sclk_in(sclk_w),
      .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out),
      .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
      .ss_in(sl_ss_n), .ss_out(ss_out)
   );
   spi_slave_model u_spi_slave_model (
      .clk(sys_clk), .sclk(sclk_w), .mosi(mosi_w), .sel_n(part_sel_n), .cpol(part_cpol),
      .cpha(part_cpha), .reply(REPLY), .miso(miso_m), .got(got)
   );

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
      checks++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask : check

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // Word as it appears on the line, first bit highest
   function automatic logic [15:0] line_val(input logic [15:0] w, input int n);
      logic [15:0] v;
      v = '0;
      for (int i = 0; i < n; i++) v[n - 1 - i] = lsb_first ? w[i] : w[n - 1 - i];
      return v;
   endfunction : line_val

   function automatic logic [15:0] reply_at(input int off, input int n);
      logic [15:0] v;
      v = '0;
      for (int i = 0; i < n; i++) v[n - 1 - i] = REPLY[63 - off - i];
      return v;
   endfunction : reply_at

   task automatic setup(input logic [1:0] vr, input logic [2:0] cfg, input int l, input int r,
                        input logic ls, input logic [1:0] ix);
      @(posedge sys_clk);
      interface_control_reg <= {6'h0, vr, 20'h0, cfg, 1'b0};
      lsb_first <= ls;
      ss_index <= ix;
      tx_len_in <= 5'(l);
      rx_len_in <= 5'(r);
      len_we <= 1'b1;
      len = (l < 4) ? 4 : (l > 16) ? 16 : l;
      rlen = (r < 4) ? 4 : (r > 16) ? 16 : r;
      @(posedge sys_clk);
      len_we <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : setup

   // Bounded wait until every expected word has arrived
   task automatic drain();
      int w;
      w = 0;
      while (expq.size() != 0 && w < 5000) begin
         @(posedge sys_clk);
         w++;
      end
      check("missing words", 16'(expq.size()), 16'h0);
      expq.delete();
      repeat (4) @(posedge sys_clk);
   endtask : drain

   // Master frames with valid held high, so consecutive frames run back to back
   task automatic xfer(input int n);
      exp_t e;
      int w;
      t_rx.delete();
      for (int k = 0; k < n; k++) begin
         seed = lfsr(seed);
         tx_data <= seed;
         tx_valid <= 1'b1;
         e.tx = line_val(seed, len);
         e.mask = 16'((32'h1 << len) - 1);
         e.ctx = (mode_v != VAR_HALF);
         e.crx = (mode_v == VAR_SEL) || (mode_v == VAR_HALF && k == 0);
         e.rx = (mode_v == VAR_HALF) ? reply_at(len + 1, rlen) :
                line_val(reply_at(k * len, len), len);
         expq.push_back(e);
         w = 0;
         do begin
            @(posedge sys_clk);
            w++;
         end while (tx_ready !== 1'b1 && w < 5000);
         if (mode_v != VAR_PULSE) begin
            repeat (2) @(posedge sys_clk);
            check("select", {12'h0, ss_out}, {12'h0, ~(4'h1 << ss_index)});
         end
      end
      tx_valid <= 1'b0;
      drain();
      check("idle clock", {15'h0, sclk_out}, {15'h0, part_cpol});
      check("idle select", {12'h0, ss_out}, (mode_v == VAR_PULSE) ? 16'h0 : 16'hf);
      check("busy", {15'h0, busy}, 16'h0);
      check("master drives", {13'h0, sclk_oe_n, mosi_oe_n, miso_oe_n}, 16'h1);
      if (n == 2) begin
         w = (mode_v == VAR_HALF) ? len + 1 + rlen : len;
         check("frame spacing", 16'(t_rx[1] - t_rx[0]), 16'(BIT * w));
      end
   endtask : xfer

   // Scoreboard of received words and select pulse width
   always @(posedge sys_clk) begin
      exp_t e;
      cyc++;
      if (rx_valid === 1'b1) begin
         t_rx.push_back(cyc);
         if (expq.size() == 0) begin
            check("extra word", 16'h1, 16'h0);
         end else begin
            e = expq.pop_front();
            if (e.crx) check("rx_data", rx_data, e.rx);
            if (e.ctx) check("mosi stream", got[15:0] & e.mask, e.tx);
         end
      end
      // Gated by busy so the stale idle select of the previous variant is not counted
      if (mode_v == VAR_PULSE && busy === 1'b1 && ss_out[ss_index] === 1'b1) begin
         pw++;
      end else if (pw != 0) begin
         check("pulse width", 16'(pw), 16'(BIT));
         pw = 0;
      end
   end

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Run needs a few thousand cycles; this allows fifty thousand
   initial begin
      #500000;
      bad_count++;
      print_verdict();
   end

   initial begin
      rst_n = 1'b0;
      master_mode = 1'b1;
      lsb_first = 1'b0;
      len_we = 1'b0;
      tx_valid = 1'b0;
      ss_index = 2'h0;
      tx_len_in = 5'h08;
      rx_len_in = 5'h04;
      tx_data = 16'h0;
      block_control_reg = 32'h0100_0000;
      interface_control_reg = 32'h0;
      sl_sclk = 1'b0;
      sl_mosi = 1'b0;
      sl_ss_n = 1'b1;
      seed = 16'h0019;
      len = 8;
      rlen = 8;
      repeat (10) @(posedge sys_clk);
      check("reset select", {12'h0, ss_out}, 16'hf);
      rst_n <= 1'b1;
      xfer(1);
      // Every clock mode, boundary and clamped lengths, both orders
      for (int m = 0; m < 4; m++) begin
         setup(VAR_SEL, {m[1:0], 1'b0}, LENS[m], 8, m[0], m[1:0]);
         xfer(2);
      end
      setup(VAR_PULSE, 3'h0, 8, 8, 1'b1, 2'h2);
      xfer(2);
      setup(VAR_PULSE, 3'h1, 12, 8, 1'b0, 2'h1);
      xfer(2);
      setup(VAR_HALF, 3'h0, 8, 4, 1'b0, 2'h3);
      xfer(2);
      // Slave splits one long select into two frames by counting
      master_mode <= 1'b0;
      setup(VAR_SEL, 3'h0, 8, 8, 1'b0, 2'h0);
      expq.push_back('{16'h00a6, 16'h0, 16'h0, 1'b1, 1'b0});
      expq.push_back('{16'h0059, 16'h0, 16'h0, 1'b1, 1'b0});
      // Reply word loaded while deselected; held valid so both frames send it
      tx_data <= 16'h00c5;
      tx_valid <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sl_ss_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sl_mosi <= SLV[i];
         #62.5 sl_sclk <= 1'b1;
         mrx = {mrx[14:0], miso_w};
         #62.5 sl_sclk <= 1'b0;
      end
      #200 sl_ss_n <= 1'b1;
      tx_valid <= 1'b0;
      drain();
      check("slave reply", mrx, 16'hc5c5);
      check("slave drives", {13'h0, sclk_oe_n, mosi_oe_n, miso_oe_n}, 16'h7);
      master_mode <= 1'b1;
      // Disabled engine never takes a frame
      for (int k = 0; k < 2; k++) begin
         block_control_reg <= k ? 32'h0100_0000 : 32'h0200_0000;
         interface_control_reg <= k ? 32'h0300_0000 : 32'h0;
         tx_valid <= 1'b1;
         cnt = 0;
         repeat (40) begin
            @(posedge sys_clk);
            cnt += (tx_ready === 1'b1);
         end
         check("taken while off", 16'(cnt), 16'h0);
      end
      tx_valid <= 1'b0;
      print_verdict();
   end
endmodule : spi_master_slave_engine_tb_top

// ==== tb/spi_slave_model.sv ====
`timescale 1ns/100ps
// Far-side slave, sampled on the bench clock so it never races the engine's
// registered pins; its answers lag each serial edge by one system cycle.
module spi_slave_model (
   input wire logic clk, // Bench sampling clock
   input wire logic sclk, // Serial clock from the master
   input wire logic mosi, // Data from the master
   input wire logic sel_n, // Select, low active
   input wire logic cpol, // Idle clock level
   input wire logic cpha, // Sample on trailing edge when set
   input wire logic [63:0] reply, // Reply stream, first bit at 63
   output logic miso, // Data to the master
   output logic [63:0] got // Captured master bits, newest at 0
);
   logic ps;
   logic pn;
   int ntx;
   initial begin
      ps = 1'b0;
      pn = 1'b1;
      ntx = 0;
      miso = 1'b0;
      got = '0;
   end
   // Edge detection on the sampled pins
   always @(posedge clk) begin
      if (pn && !sel_n && !cpha) begin
         miso <= reply[63];
         ntx = 1;
      end else if (!sel_n && sclk != ps) begin
         if ((sclk != cpol) != cpha) begin
            got <= {got[62:0], mosi};
         end else begin
            miso <= reply[6'(63 - ntx)];
            ntx = ntx + 1;
         end
      // Released line shows the inverse of its last value
      end else if (sel_n && !pn) begin
         miso <= ~miso;
         ntx = 0;
      end
      ps = sclk;
      pn = sel_n;
   end
endmodule : spi_slave_model
